// file: sfs_pkg.sv
// Package for the default start-up write sequencer: step layout, defaults, timing
package sfs_pkg;

    // ------------------------------------------------------------
    // Launch command and program geometry
    // ------------------------------------------------------------
    localparam logic [7:0]  SFS_LAUNCH_ADDR  = 8'h6f;
    localparam logic [15:0] SFS_LAUNCH_VALUE = 16'h0100;
    localparam logic [4:0]  SFS_START_INDEX  = 5'h00;
    localparam int          SFS_STEP_COUNT   = 25;
    localparam logic [4:0]  SFS_LAST_INDEX   = 5'h18;
    localparam logic [7:0]  SFS_DUMMY_ADDR   = 8'hff;

    // ------------------------------------------------------------
    // Timing: each step lasts k * (2^delay + 8)
    // ------------------------------------------------------------
    localparam int          SFS_CLK_PERIOD_NS = 20;
    localparam int          SFS_K_NS          = 62500;
    localparam int          SFS_TICK_CYCLES   =
        (SFS_K_NS + SFS_CLK_PERIOD_NS - 1) / SFS_CLK_PERIOD_NS;
    localparam logic [15:0] SFS_DELAY_BASE    = 16'h0008;
    localparam int          SFS_RUN_MS        = 300;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] target;
        logic [3:0] startBit;
        logic [2:0] stepFieldWidthCode;
        logic [7:0] data;
        logic       stepEndFlag;
        logic [3:0] stepDelayCode;
    } sfs_step_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  addr;
        logic [15:0] mask;
        logic [15:0] data;
    } sfs_ctrl_wr_t;

    typedef enum logic [1:0] {
        SFS_IDLE,
        SFS_EXEC,
        SFS_WAIT
    } sfs_state_t;

    // ------------------------------------------------------------
    // Power-up contents of the step store
    // ------------------------------------------------------------
    localparam sfs_step_t SFS_DUMMY_STEP = '{8'hff, 4'h0, 3'h0, 8'h00, 1'b0, 4'h0};

    localparam sfs_step_t [SFS_STEP_COUNT-1:0] SFS_DEFAULT_PROGRAM = '{
        0:  '{8'h04, 4'h0, 3'h4, 8'h1a, 1'b0, 4'h0},
        1:  '{8'h05, 4'h0, 3'h7, 8'h47, 1'b0, 4'h6},
        2:  '{8'h05, 4'h1, 3'h1, 8'h01, 1'b0, 4'h0},
        3:  '{8'h04, 4'h0, 3'h0, 8'h01, 1'b0, 4'h0},
        4:  '{8'h0e, 4'h0, 3'h1, 8'h03, 1'b0, 4'h0},
        5:  '{8'h0f, 4'h0, 3'h1, 8'h03, 1'b0, 4'h0},
        6:  '{8'h16, 4'h1, 3'h0, 8'h01, 1'b0, 4'h0},
        7:  '{8'h12, 4'h2, 3'h1, 8'h03, 1'b0, 4'h5},
        8:  SFS_DUMMY_STEP,
        9:  '{8'h04, 4'h4, 3'h0, 8'h00, 1'b0, 4'h0},
        10: '{8'h62, 4'h0, 3'h0, 8'h01, 1'b0, 4'h6},
        11: SFS_DUMMY_STEP,
        12: '{8'h5a, 4'h0, 3'h7, 8'h11, 1'b0, 4'h0},
        13: '{8'h5e, 4'h0, 3'h7, 8'h11, 1'b0, 4'h0},
        14: '{8'h5a, 4'h0, 3'h7, 8'h33, 1'b0, 4'h0},
        15: '{8'h5e, 4'h0, 3'h7, 8'h33, 1'b0, 4'h0},
        16: '{8'h43, 4'h0, 3'h3, 8'h0f, 1'b0, 4'hc},
        17: '{8'h44, 4'h0, 3'h7, 8'hf0, 1'b0, 4'h0},
        18: SFS_DUMMY_STEP,
        19: '{8'h5a, 4'h0, 3'h7, 8'h77, 1'b0, 4'h0},
        20: '{8'h5e, 4'h0, 3'h7, 8'h77, 1'b0, 4'h0},
        21: '{8'h5a, 4'h0, 3'h7, 8'hff, 1'b0, 4'h0},
        22: '{8'h5e, 4'h0, 3'h7, 8'hff, 1'b1, 4'h0},
        23: SFS_DUMMY_STEP,
        24: SFS_DUMMY_STEP
    };

endpackage : sfs_pkg

// file: sfs_startup_seq.sv
// Default start-up write sequencer: step store, launch decode, step timing, field writes
//
// Notes on behaviour
// - Writing 0100h to 6Fh launches program
// - Start at index zero, ascend until end
// - Step 1 writes 47h to 05h, delay 6h
// - Step 2 updates 05h bits 2:1 with 01h
// - Steps 8, 11, 18 are dummy FFh writes
// - Step 20 writes 77h into 5Eh
// - Step 22 writes FFh, carries end flag
// - Whole default program takes about 300 ms
// - Step lasts k times (2^delay plus 8)
// - Width code selects 1 to 8 data bits
// - End flag halts after step's delay
// - Entries rewritable; kept until power loss
`timescale 1ns/100ps

module sfs_startup_seq
    import sfs_pkg::*;
#(
    parameter int TICK_CYCLES = sfs_pkg::SFS_TICK_CYCLES
) (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  ctrlWrEn,
    input  wire logic [7:0]            ctrlWrAddr,
    input  wire logic [15:0]           ctrlWrValue,
    input  wire logic                  stepWrEn,
    input  wire logic [4:0]            stepWrIndex,
    input  wire sfs_pkg::sfs_step_t    stepWrEntry,
    output sfs_pkg::sfs_ctrl_wr_t      regWrite,
    output logic                       busy,
    output logic                       seqDone,
    output logic [4:0]                 stepProgramPointer
);
    import sfs_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (TICK_CYCLES < 2 || TICK_CYCLES > 4095) begin : g_bad_tick
        $error("TICK_CYCLES must lie in 2..4095");
    end

    localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        sfs_state_t                        phase;
        logic [4:0]                        ptr;
        logic [11:0]                       divCnt;
        logic [15:0]                       ticksLeft;
        logic                              busy;
        logic                              done;
        sfs_ctrl_wr_t                      wr;
        sfs_step_t [SFS_STEP_COUNT-1:0]    prog;
    } sfs_core_t;

    // Async reset stands for power loss; the store is refilled from constants
    localparam sfs_core_t CORE_RESET = '{
        phase:     SFS_IDLE,
        ptr:       SFS_START_INDEX,
        divCnt:    12'h000,
        ticksLeft: 16'h0000,
        busy:      1'b0,
        done:      1'b0,
        wr:        '0,
        prog:      SFS_DEFAULT_PROGRAM
    };

    sfs_core_t core_reg;
    sfs_core_t core_next;
    sfs_step_t cur;
    logic [7:0] widthMask;
    logic       launch;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        core_next  = core_reg;
        cur        = core_reg.prog[core_reg.ptr];
        widthMask  = 8'((9'h002 << cur.stepFieldWidthCode) - 9'h001);
        launch     = ctrlWrEn && ctrlWrAddr == SFS_LAUNCH_ADDR
                     && ctrlWrValue == SFS_LAUNCH_VALUE;
        core_next.wr.valid = 1'b0;

        // Software may rewrite any entry at any time, even mid-run
        if (stepWrEn && stepWrIndex <= SFS_LAST_INDEX) begin
            core_next.prog[stepWrIndex] = stepWrEntry;
        end

        case (core_reg.phase)
            SFS_IDLE: begin
                // A launch during a run is ignored rather than restarting mid-ramp
                if (launch) begin
                    core_next.phase = SFS_EXEC;
                    core_next.ptr   = SFS_START_INDEX;
                    core_next.busy  = 1'b1;
                    core_next.done  = 1'b0;
                end
            end
            SFS_EXEC: begin
                // Dummy target consumes its delay but issues nothing
                core_next.wr.valid = cur.target != SFS_DUMMY_ADDR;
                core_next.wr.addr  = cur.target;
                core_next.wr.mask  = 16'({8'h00, widthMask}) << cur.startBit;
                core_next.wr.data  = 16'({8'h00, cur.data & widthMask}) << cur.startBit;
                core_next.divCnt    = 12'h001;
                core_next.ticksLeft = (16'h0001 << cur.stepDelayCode) + SFS_DELAY_BASE;
                core_next.phase     = SFS_WAIT;
            end
            SFS_WAIT: begin
                if (core_reg.divCnt == TICK_LAST) begin
                    core_next.divCnt = 12'h000;
                    if (core_reg.ticksLeft == 16'h0001) begin
                        // Step fully elapsed, delay included
                        if (cur.stepEndFlag || core_reg.ptr == SFS_LAST_INDEX) begin
                            core_next.phase = SFS_IDLE;
                            core_next.busy  = 1'b0;
                            core_next.done  = cur.stepEndFlag;
                        end else begin
                            core_next.ptr   = core_reg.ptr + 5'h01;
                            core_next.phase = SFS_EXEC;
                        end
                    end else begin
                        core_next.ticksLeft = core_reg.ticksLeft - 16'h0001;
                    end
                end else begin
                    core_next.divCnt = core_reg.divCnt + 12'h001;
                end
            end
            default: begin
                core_next.phase = SFS_IDLE;
                core_next.busy  = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            core_reg <= CORE_RESET;
        end else begin
            core_reg <= core_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign regWrite           = core_reg.wr;
    assign busy               = core_reg.busy;
    assign seqDone            = core_reg.done;
    assign stepProgramPointer = core_reg.ptr;

endmodule : sfs_startup_seq

// file: sfs_startup_seq_monitor.sv
// Port checker for the start-up write sequencer
`timescale 1ns/100ps
module sfs_seq_monitor
    import sfs_pkg::*;
#(
    parameter int TICK_CYCLES = sfs_pkg::SFS_TICK_CYCLES
) (
    input wire logic         mclk,
    input wire logic         rst_n,
    input wire logic         ctrlWrEn,
    input wire logic [7:0]   ctrlWrAddr,
    input wire logic [15:0]  ctrlWrValue,
    input wire logic         stepWrEn,
    input wire logic [4:0]   stepWrIndex,
    input wire sfs_step_t    stepWrEntry,
    input wire sfs_ctrl_wr_t regWrite,
    input wire logic         busy,
    input wire logic         seqDone,
    input wire logic [4:0]   stepProgramPointer
);
    // ------
    // Sequencer checks
    // ------
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Cycles since the last issued write; idle time only lengthens it
    logic [31:0] sinceWr;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sinceWr <= 32'h0000_0000;
        end else if (regWrite.valid) begin
            sinceWr <= 32'h0000_0001;
        end else if (sinceWr != 32'h0000_0000) begin
            sinceWr <= sinceWr + 32'h0000_0001;
        end
    end
    sequence launchS;
        ctrlWrEn && ctrlWrAddr == SFS_LAUNCH_ADDR && ctrlWrValue == SFS_LAUNCH_VALUE && !busy;
    endsequence
    AST_LAUNCH: assert property (launchS |=> busy && !seqDone && stepProgramPointer == 5'h00)
        else $error("launch not taken");
    AST_FIRST: assert property (launchS |-> ##2 regWrite.valid) else $error("no first write");
    AST_ASCEND: assert property (busy && $past(busy) && $changed(stepProgramPointer)
        |-> stepProgramPointer == $past(stepProgramPointer) + 5'h01) else $error("index skip");
    AST_MIN_STEP: assert property ($rose(busy) |-> busy [*8]) else $error("step too short");
    AST_PULSE: assert property (regWrite.valid |=> !regWrite.valid) else $error("long pulse");
    AST_DUMMY: assert property (regWrite.valid |-> busy && regWrite.addr != SFS_DUMMY_ADDR)
        else $error("dummy target written");
    AST_FIELD: assert property (regWrite.valid
        |-> (regWrite.data & ~regWrite.mask) == 16'h0000) else $error("data outside field");
    AST_END: assert property ($fell(busy) |-> seqDone) else $error("end flag lost");
    // Shortest step is delay code 0, so writes are never closer than base plus one ticks
    AST_STEP_GAP: assert property (regWrite.valid && sinceWr != 32'h0000_0000
        |-> sinceWr >= 32'(TICK_CYCLES * (int'(SFS_DELAY_BASE) + 1)))
        else $error("writes closer than the shortest step");
endmodule : sfs_seq_monitor

// file: sfs_startup_seq_tb.sv
// Self-checking bench for the start-up write sequencer
`timescale 1ns/100ps
module testbench;
    import sfs_pkg::*;
    localparam int TK = 4;
    logic         mclk = 0, rst_n = 0, ctrlWrEn = 0, stepWrEn = 0, busy, seqDone;
    logic [15:0]  ctrlWrValue = 16'h0000, wM [25], wD [25];
    logic [7:0]   ctrlWrAddr = 8'h6f, wAd [25];
    logic [4:0]   stepWrIndex = 5'h00, ptr;
    sfs_step_t    stepWrEntry = '0;
    sfs_ctrl_wr_t regWrite;
    int           nFail = 0, samplesChecked = 0, nWr, runLen, wT [25];
    // ------
    // Clock, design and shared tasks
    // ------
    always #10 mclk = ~mclk;
    sfs_startup_seq #(.TICK_CYCLES(TK)) dut_u (.mclk(mclk), .rst_n(rst_n), .ctrlWrEn(ctrlWrEn),
        .ctrlWrAddr(ctrlWrAddr), .ctrlWrValue(ctrlWrValue), .stepWrEn(stepWrEn),
        .stepWrIndex(stepWrIndex), .stepWrEntry(stepWrEntry), .regWrite(regWrite),
        .busy(busy), .seqDone(seqDone), .stepProgramPointer(ptr));
    task automatic chk(input string what, input logic [39:0] want, input logic [39:0] got);
        samplesChecked++;
        nFail += (got !== want);
        if (got !== want) $display("Error %s expected %h seen %h", what, want, got);
    endtask : chk
    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", samplesChecked, nFail);
        if (nFail == 0 && samplesChecked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic ctl, input logic [15:0] v, input logic [4:0] i,
                      input sfs_step_t e);
        @(posedge mclk);
        {ctrlWrEn, stepWrEn} <= {ctl, !ctl};
        {ctrlWrValue, stepWrIndex, stepWrEntry} <= {v, i, e};
        @(posedge mclk);
        {ctrlWrEn, stepWrEn} <= 2'b00;
    endtask : wr
    // Bounded so a stuck sequencer cannot hang the run
    task automatic run_prog;
        nWr = 0;
        wr(1'b1, SFS_LAUNCH_VALUE, 5'h00, '0);
        for (runLen = 0; runLen < 20000; runLen++) begin
            @(negedge mclk);
            if (busy !== 1'b1) break;
            if (regWrite.valid === 1'b1) begin
                {wAd[ptr], wM[ptr], wD[ptr], wT[ptr]} =
                    {regWrite.addr, regWrite.mask, regWrite.data, runLen};
                nWr++;
            end
        end
        nFail += (runLen == 20000);
        if (runLen == 20000) report_and_stop();
    endtask : run_prog
    task automatic test_default;
        wr(1'b0, 16'h0000, 5'h12, SFS_DUMMY_STEP);
        run_prog();
        chk("write count", 20, nWr);
        chk("run cycles", TK * 4459, runLen);
        chk("step 1", {8'h05, 16'h00ff, 16'h0047}, {wAd[1], wM[1], wD[1]});
        chk("step 1 span", TK * 72, wT[2] - wT[1]);
        chk("step 2", {8'h05, 16'h0006, 16'h0002}, {wAd[2], wM[2], wD[2]});
        chk("step 20", {8'h5e, 16'h00ff, 16'h0077}, {wAd[20], wM[20], wD[20]});
        chk("step 22", {8'h5e, 16'h00ff, 16'h00ff}, {wAd[22], wM[22], wD[22]});
        chk("end state", 6'h36, {seqDone, ptr});
    endtask : test_default
    task automatic test_custom;
        wr(1'b0, 16'h0000, 5'h01, '{8'h05, 4'h4, 3'h2, 8'hff, 1'b0, 4'h0});
        wr(1'b0, 16'h0000, 5'h03, '{8'h04, 4'h0, 3'h0, 8'h01, 1'b1, 4'h0});
        run_prog();
        chk("short run", TK * 36, runLen);
        chk("narrow field", {8'h05, 16'h0070, 16'h0070}, {wAd[1], wM[1], wD[1]});
        wr(1'b1, 16'h0119, 5'h00, '0);
        repeat (3) @(negedge mclk);
        chk("wrong value busy", 1'b0, busy);
        @(posedge mclk);
        ctrlWrAddr <= 8'h6e;
        wr(1'b1, SFS_LAUNCH_VALUE, 5'h00, '0);
        @(posedge mclk);
        ctrlWrAddr <= SFS_LAUNCH_ADDR;
        repeat (2) @(negedge mclk);
        chk("wrong address state", 2'b10, {seqDone, busy});
    endtask : test_custom
    // Power loss in mid-run must clear the outputs and refill the store
    task automatic test_power_loss;
        wr(1'b1, SFS_LAUNCH_VALUE, 5'h00, '0);
        repeat (50) @(posedge mclk);
        rst_n <= 1'b0;
        @(negedge mclk);
        chk("reset outputs", 8'h00, {busy, seqDone, ptr, regWrite.valid});
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        run_prog();
        chk("rerun cycles", TK * 4459, runLen);
        chk("restored step 1", {8'h05, 16'h00ff, 16'h0047}, {wAd[1], wM[1], wD[1]});
        chk("restored end", 6'h36, {seqDone, ptr});
    endtask : test_power_loss
    initial begin
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        test_default();
        test_custom();
        test_power_loss();
        report_and_stop();
    end
endmodule : testbench
bind sfs_startup_seq sfs_seq_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_u (.mclk(mclk),
    .rst_n(rst_n),
    .ctrlWrEn(ctrlWrEn), .ctrlWrAddr(ctrlWrAddr), .ctrlWrValue(ctrlWrValue), .stepWrEn(stepWrEn),
    .stepWrIndex(stepWrIndex), .stepWrEntry(stepWrEntry), .regWrite(regWrite), .busy(busy),
    .seqDone(seqDone), .stepProgramPointer(stepProgramPointer));
